// file: design/eis_top.sv
/*
  External interrupt sense control and sleep controller with APB access.
  Assumes one pclk domain; pins and the watchdog oscillator are sampled.
  The core pulses halt_exec on the halt opcode and irq_ack on vectoring.
*/
`timescale 1ns/10ps
`default_nettype none
module eis_top
  import eis_pkg::*;
#(
  parameter int WAKE_PERIOD_CYC = 64,
  parameter int STARTUP_CYC_0 = 16,
  parameter int STARTUP_CYC_1 = 256,
  parameter int STARTUP_CYC_2 = 1024,
  parameter int STARTUP_CYC_3 = 4096
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_irq_pin_0,
  input wire logic ext_irq_pin_1,
  input wire logic wdt_osc_raw,
  input wire logic cpu_global_irq_enable,
  input wire logic halt_exec,
  input wire logic [1:0] irq_ack,
  input wire logic internal_irq_wake,
  input wire logic [1:0] clock_source_fuses,
  output logic [1:0] irq_req,
  output logic cpu_clk_stop,
  output logic osc_stop,
  output logic wake_pulse
);

  localparam int CNT_W = 16;

  eis_ctrl_t ctrl;
  logic [1:0] mask;
  logic [1:0] pend;
  eis_pin_t ev0;
  eis_pin_t ev1;
  eis_state_t state;
  eis_state_t next_state;
  logic [CNT_W-1:0] qual_cnt;
  logic [1:0] qual_wdt;
  logic [CNT_W-1:0] start_cnt;
  logic w1;
  logic w2;
  logic w3;
  logic wdt_filt;
  logic wdt_prev;

  logic [ADDR_W-3:0] idx;
  logic setup;
  logic wr_fire;
  logic mapped;
  logic [1:0] mode0;
  logic [1:0] mode1;
  logic [1:0] level_low;
  logic [1:0] edge_hit;
  logic [1:0] lvl_mode;
  logic [1:0] req_raw;
  logic [1:0] enabled;
  logic lvl_wake;
  logic wdt_rise;
  logic qualified;
  logic start_done;

  function automatic logic [CNT_W-1:0] startup_len(input logic [1:0] f);
    logic [CNT_W-1:0] n;
    n = '0;
    case (f)
      2'h0: n = CNT_W'(STARTUP_CYC_0);
      2'h1: n = CNT_W'(STARTUP_CYC_1);
      2'h2: n = CNT_W'(STARTUP_CYC_2);
      default: n = CNT_W'(STARTUP_CYC_3);
    endcase
    return n;
  endfunction : startup_len

  assign idx = paddr[ADDR_W-1:2];
  assign setup = psel & ~penable;
  assign wr_fire = psel & penable & pready & pwrite & ~pslverr;
  assign mapped = (paddr[1:0] == 2'h0) &&
                  (idx == IDX_CTRL || idx == IDX_MASK || idx == IDX_STAT);

  assign mode0 = {ctrl.pin0_sense_hi, ctrl.pin0_sense_lo};
  assign mode1 = {ctrl.pin1_sense_hi, ctrl.pin1_sense_lo};

  eis_sense u_sense0 (
    .pclk(pclk),
    .presetn(presetn),
    .pin_raw(ext_irq_pin_0),
    .mode(mode0),
    .pin_ev(ev0)
  );

  eis_sense u_sense1 (
    .pclk(pclk),
    .presetn(presetn),
    .pin_raw(ext_irq_pin_1),
    .mode(mode1),
    .pin_ev(ev1)
  );

  assign level_low = {ev1.level_low, ev0.level_low};
  assign edge_hit = {ev1.edge_hit, ev0.edge_hit};
  assign lvl_mode = {mode1 == SENSE_LOW, mode0 == SENSE_LOW};

  // level mode requests straight from the pin, so it repeats while low
  assign req_raw = (lvl_mode & level_low) | (~lvl_mode & pend);
  assign enabled = req_raw & mask & {2{cpu_global_irq_enable}};
  assign lvl_wake = |(lvl_mode & level_low & mask) &
                    cpu_global_irq_enable;

  // control register: only the bus ever writes it, never sleep entry/exit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= RST_CTRL;
    end else if (wr_fire && idx == IDX_CTRL && pstrb[0]) begin
      ctrl <= pwdata[7:0] & CTRL_RW_MASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask <= RST_MASK;
    end else if (wr_fire && idx == IDX_MASK && pstrb[0]) begin
      mask <= pwdata[1:0] & MASK_RW_MASK;
    end
  end

  // edge flags: a new edge in the ack cycle wins over the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend <= 2'h0;
    end else begin
      pend <= (pend & ~irq_ack) | (edge_hit & ~lvl_mode);
    end
  end

  // watchdog oscillator: three samples, change counts when two agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      w1 <= 1'b0;
      w2 <= 1'b0;
      w3 <= 1'b0;
      wdt_filt <= 1'b0;
      wdt_prev <= 1'b0;
    end else begin
      w1 <= wdt_osc_raw;
      w2 <= w1;
      w3 <= w2;
      if (w2 == w3) begin
        wdt_filt <= w3;
      end
      wdt_prev <= wdt_filt;
    end
  end

  assign wdt_rise = wdt_filt & ~wdt_prev;
  // two watchdog edges, or the shorter wake period, whichever comes first
  assign qualified = (qual_wdt >= WAKE_WDT_EDGES) ||
                     (qual_cnt >= CNT_W'(WAKE_PERIOD_CYC));
  assign start_done = (start_cnt == '0);

  always_comb begin
    next_state = state;
    case (state)
      ST_RUN: begin
        if (halt_exec && ctrl.sleep_arm) begin
          next_state = ctrl.sleep_depth_select ? ST_PD_QUAL : ST_IDLE;
        end
      end
      ST_IDLE: begin
        // timers and interrupt logic run on; any enabled source wakes
        if (|enabled || internal_irq_wake) begin
          next_state = ST_RUN;
        end
      end
      ST_PD_QUAL: begin
        // edges stay latched here but cannot wake the core
        if (lvl_wake && qualified) begin
          next_state = ST_PD_START;
        end
      end
      ST_PD_START: begin
        if (start_done) begin
          next_state = ST_RUN;
        end
      end
      default: next_state = ST_RUN;
    endcase
  end

  // reset from any state lands in run, so the core restarts from reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_RUN;
    end else begin
      state <= next_state;
    end
  end

  // persistence counters restart whenever the level drops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      qual_cnt <= '0;
      qual_wdt <= 2'h0;
    end else if (state != ST_PD_QUAL || !lvl_wake) begin
      qual_cnt <= '0;
      qual_wdt <= 2'h0;
    end else begin
      if (qual_cnt != '1) begin
        qual_cnt <= qual_cnt + CNT_W'(1);
      end
      if (wdt_rise && qual_wdt != 2'h3) begin
        qual_wdt <= qual_wdt + 2'h1;
      end
    end
  end

  // start delay length follows the clock source fuses
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_cnt <= '0;
    end else if (state == ST_PD_QUAL && next_state == ST_PD_START) begin
      start_cnt <= startup_len(clock_source_fuses);
    end else if (state == ST_PD_START && !start_done) begin
      start_cnt <= start_cnt - CNT_W'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_clk_stop <= 1'b0;
      osc_stop <= 1'b0;
      wake_pulse <= 1'b0;
    end else begin
      cpu_clk_stop <= (next_state != ST_RUN);
      osc_stop <= (next_state == ST_PD_QUAL);
      wake_pulse <= (state != ST_RUN) && (next_state == ST_RUN);
    end
  end

  // requests are held off while the core sleeps in power-down; a level
  // gone by the end of the start delay yields no request at all
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_req <= 2'h0;
    end else if (state == ST_PD_QUAL || state == ST_PD_START) begin
      irq_req <= 2'h0;
    end else begin
      irq_req <= enabled;
    end
  end

  // zero wait state slave: answer is ready in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= setup;
      pslverr <= setup & ~mapped;
      if (setup && !pwrite && mapped) begin
        case (idx)
          IDX_CTRL: prdata <= {24'h0, ctrl & CTRL_RW_MASK};
          IDX_MASK: prdata <= {30'h0, mask};
          IDX_STAT: begin
            prdata <= 32'h0;
            prdata[POS_STAT_IDLE] <= (state == ST_IDLE);
            prdata[POS_STAT_PD] <= (state == ST_PD_QUAL) ||
                                   (state == ST_PD_START);
            prdata[POS_STAT_LEVEL +: 2] <= level_low;
            prdata[POS_STAT_PEND +: 2] <= pend;
          end
          default: prdata <= 32'h0;
        endcase
      end else if (setup) begin
        prdata <= 32'h0;
      end
    end
  end

endmodule : eis_top
`default_nettype wire

// file: design/eis_pkg.sv
/*
  Shared constants, field layouts and types for the external interrupt
  sense and sleep control block.
  Assumes an APB register bus with 32-bit data and one pclk domain.
*/
package eis_pkg;

  // word indices; byte address is four times the index
  localparam int ADDR_W = 10;
  localparam logic [7:0] IDX_CTRL = 8'h35;
  localparam logic [7:0] IDX_MASK = 8'h36;
  localparam logic [7:0] IDX_STAT = 8'h37;

  // sleep_and_int_sense_control field positions
  localparam int POS_SLEEP_ARM = 5;
  localparam int POS_SLEEP_DEPTH = 4;
  localparam int POS_PIN1_SENSE = 2;
  localparam int POS_PIN0_SENSE = 0;
  localparam logic [7:0] CTRL_RW_MASK = 8'h3f;
  localparam logic [7:0] RST_CTRL = 8'h00;

  // ext_irq_mask_register: bit 0 pin 0, bit 1 pin 1
  localparam logic [1:0] MASK_RW_MASK = 2'h3;
  localparam logic [1:0] RST_MASK = 2'h0;

  // status word field positions
  localparam int POS_STAT_IDLE = 0;
  localparam int POS_STAT_PD = 1;
  localparam int POS_STAT_LEVEL = 2;
  localparam int POS_STAT_PEND = 4;

  // pins idle high behind a pull-up
  localparam logic PIN_IDLE = 1'b1;

  // level must persist this many watchdog oscillator edges, or WAKE_PERIOD_CYC cycles
  localparam logic [1:0] WAKE_WDT_EDGES = 2'h2;

  typedef enum logic [1:0] {
    SENSE_LOW  = 2'b00,
    SENSE_ANY  = 2'b01,
    SENSE_FALL = 2'b10,
    SENSE_RISE = 2'b11
  } eis_sense_t;

  typedef enum logic [3:0] {
    ST_RUN      = 4'b0001,
    ST_IDLE     = 4'b0010,
    ST_PD_QUAL  = 4'b0100,
    ST_PD_START = 4'b1000
  } eis_state_t;

  typedef struct packed {
    logic [1:0] resv;
    logic sleep_arm;
    logic sleep_depth_select;
    logic pin1_sense_hi;
    logic pin1_sense_lo;
    logic pin0_sense_hi;
    logic pin0_sense_lo;
  } eis_ctrl_t;

  typedef struct packed {
    logic level_low;
    logic edge_hit;
  } eis_pin_t;

  function automatic logic eis_edge_hit(input logic [1:0] mode,
                                        input logic prev,
                                        input logic cur);
    logic hit;
    hit = 1'b0;
    case (mode)
      SENSE_ANY: hit = prev ^ cur;
      SENSE_FALL: hit = prev & ~cur;
      SENSE_RISE: hit = ~prev & cur;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction : eis_edge_hit

endpackage : eis_pkg

// file: design/eis_sense.sv
/*
  Per-pin sampler and edge detector for one external interrupt pin.
  Assumes the pin is asynchronous to pclk; mode comes from pclk logic.
*/
`timescale 1ns/10ps
`default_nettype none
module eis_sense
  import eis_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pin_raw,
  input wire logic [1:0] mode,
  output eis_pin_t pin_ev
);

  logic s1;
  logic s2;
  logic s3;
  logic filt;
  logic prev;

  // pad level is used whatever the pin direction
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1 <= PIN_IDLE;
      s2 <= PIN_IDLE;
      s3 <= PIN_IDLE;
    end else begin
      s1 <= pin_raw;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // a change counts only once two samples agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      filt <= PIN_IDLE;
    end else if (s2 == s3) begin
      filt <= s3;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev <= PIN_IDLE;
      pin_ev <= '0;
    end else begin
      prev <= filt;
      pin_ev.edge_hit <= eis_edge_hit(mode, prev, filt);
      pin_ev.level_low <= ~filt;
    end
  end

endmodule : eis_sense
`default_nettype wire

// file: bench/eis_pin_src.sv
/*
  Far-side model: two interrupt pins with pull-ups and a watchdog osc.
  Assumes the bench requests low levels through pull_low.
*/
`timescale 1ns/10ps
`default_nettype none
module eis_pin_src (
  input wire logic pclk,
  input wire logic [1:0] pull_low,
  output logic [1:0] pins,
  output logic wdt_osc
);
  logic [1:0] div = 2'h0;
  // released pins go back high through the pull-up
  assign pins = ~pull_low;
  always @(posedge pclk) begin
    div <= div + 2'h1;
  end
  // free running, unrelated to pin activity
  assign wdt_osc = div[1];
endmodule : eis_pin_src
`default_nettype wire

// file: bench/eis_top_checker.sv
/*
  Port checks for the sense and sleep block.
  Assumes fuses pick a start delay of at least four cycles.
*/
`timescale 1ns/10ps
`default_nettype none
module eis_top_checker
  import eis_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic cpu_global_irq_enable,
  input wire logic halt_exec,
  input wire logic [1:0] irq_req,
  input wire logic cpu_clk_stop,
  input wire logic osc_stop,
  input wire logic wake_pulse
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  ready_once_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  setup_answer_a: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  resv_zero_a: assert property (
    pready && !pwrite && paddr == 10'h0d4 |-> prdata[31:6] == 26'h0)
    else $error("reserved control bits not zero");
  gie_gate_a: assert property (
    !$past(cpu_global_irq_enable) |-> irq_req == 2'h0)
    else $error("request without global enable");
  sleep_cause_a: assert property (
    $rose(cpu_clk_stop) |-> $past(halt_exec))
    else $error("sleep without halt");
  pd_in_sleep_a: assert property (osc_stop |-> cpu_clk_stop)
    else $error("oscillator stopped while running");
  pd_no_req_a: assert property (
    osc_stop && $past(osc_stop) |-> irq_req == 2'h0)
    else $error("request in power-down");
  wake_exit_a: assert property (
    wake_pulse |-> !cpu_clk_stop && $past(cpu_clk_stop))
    else $error("wake pulse without leaving sleep");
  start_delay_a: assert property (
    $fell(osc_stop) |-> cpu_clk_stop [*4])
    else $error("start delay too short");
endmodule : eis_top_checker
bind eis_top eis_top_checker u_eis_top_checker (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .prdata, .pready, .pslverr,
  .cpu_global_irq_enable, .halt_exec, .irq_req, .cpu_clk_stop, .osc_stop,
  .wake_pulse);
`default_nettype wire

// file: bench/eis_top_test.sv
/*
  Self-checking bench for the sense and sleep block.
  Assumes the pin model in eis_pin_src and the bound checker.
*/
`timescale 1ns/10ps
`default_nettype none
module eis_top_test
  import eis_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [9:0] paddr = 10'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, wdt, clk_stop, osc_stop, wake;
  logic gie = 1'b0;
  logic halt = 1'b0;
  logic iwake = 1'b0;
  logic [1:0] ack = 2'h0;
  logic [1:0] pull_low = 2'h0;
  logic [1:0] pins, req;
  logic [3:0] pstrb = 4'h1;
  logic [1:0] fuses = 2'h0;
  int waited = 0;
  int mismatches = 0;
  int comparisons = 0;
  localparam logic [9:0] A_CTRL = {IDX_CTRL, 2'b00};
  localparam logic [9:0] A_MASK = {IDX_MASK, 2'b00};
  localparam logic [9:0] A_STAT = {IDX_STAT, 2'b00};
  // longest start delay, picked by fuse code 3
  localparam int START_3 = 10;

  initial begin
    forever #2.5 pclk = ~pclk;
  end

  // short counts keep power-down waits brief
  eis_top #(.WAKE_PERIOD_CYC(8), .STARTUP_CYC_0(4), .STARTUP_CYC_1(6),
    .STARTUP_CYC_2(8), .STARTUP_CYC_3(START_3)) u_eis_top (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr,
    .ext_irq_pin_0(pins[0]), .ext_irq_pin_1(pins[1]), .wdt_osc_raw(wdt),
    .cpu_global_irq_enable(gie), .halt_exec(halt), .irq_ack(ack),
    .internal_irq_wake(iwake), .clock_source_fuses(fuses), .irq_req(req),
    .cpu_clk_stop(clk_stop), .osc_stop(osc_stop), .wake_pulse(wake));
  eis_pin_src u_eis_pin_src (.pclk, .pull_low, .pins, .wdt_osc(wdt));

  task automatic print_verdict();
    $display("compares %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int k);
    repeat (k) @(posedge pclk);
  endtask : cyc

  // idle cycle first, so psel is never set twice in one step
  task automatic apb(input logic wr, input logic [9:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      mismatches++;
      print_verdict();
    end
  endtask : apb

  task automatic wait_wake();
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (wake !== 1'b1 && n < 200);
    waited = n;
    if (n >= 200) begin
      mismatches++;
      print_verdict();
    end
  endtask : wait_wake

  // oscillator restart marks the start of the start delay
  task automatic wait_osc_run();
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (osc_stop !== 1'b0 && n < 200);
    if (n >= 200) begin
      mismatches++;
      print_verdict();
    end
  endtask : wait_osc_run

  task automatic halt_pulse();
    @(posedge pclk);
    halt <= 1'b1;
    @(posedge pclk);
    halt <= 1'b0;
    cyc(2);
  endtask : halt_pulse

  // move one pin, check the request, then acknowledge it
  task automatic pin_step(input int p, input logic lo, input logic want);
    @(posedge pclk);
    pull_low[p] <= lo;
    cyc(8);
    chk({31'h0, req[p]}, {31'h0, want});
    @(posedge pclk);
    ack[p] <= 1'b1;
    @(posedge pclk);
    ack[p] <= 1'b0;
  endtask : pin_step

  task automatic t_regs();
    apb(1'b0, A_CTRL, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, A_MASK, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, A_CTRL, 32'hff);
    apb(1'b0, A_CTRL, 32'h0);
    chk(rd, 32'h3f);
    // byte lane 0 off: the write must leave the register alone
    pstrb <= 4'h0;
    apb(1'b1, A_CTRL, 32'h0);
    pstrb <= 4'h1;
    apb(1'b0, A_CTRL, 32'h0);
    chk(rd, 32'h3f);
    apb(1'b0, 10'h3fc, 32'h0);
    chk({31'h0, err}, 32'h1);
    $display("test regs done");
  endtask : t_regs

  task automatic t_sense();
    logic [1:0] m;
    apb(1'b1, A_MASK, 32'h3);
    gie <= 1'b1;
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 4; i++) begin
        m = i[1:0];
        apb(1'b1, A_CTRL, 32'(m) << (2 * p));
        pin_step(p, 1'b1, m != SENSE_RISE);
        pin_step(p, 1'b0, m == SENSE_ANY || m == SENSE_RISE);
      end
    end
    apb(1'b1, A_MASK, 32'h1);
    apb(1'b1, A_CTRL, 32'ha);
    @(posedge pclk);
    pull_low <= 2'h3;
    cyc(8);
    chk({30'h0, req}, 32'h1);
    gie <= 1'b0;
    cyc(2);
    chk({30'h0, req}, 32'h0);
    gie <= 1'b1;
    cyc(2);
    chk({30'h0, req}, 32'h1);
    ack <= 2'h3;
    cyc(1);
    ack <= 2'h0;
    pull_low <= 2'h0;
    cyc(8);
    // a two-cycle low pulse is still wider than one clock
    @(posedge pclk);
    pull_low <= 2'h1;
    cyc(2);
    pull_low <= 2'h0;
    cyc(8);
    chk({30'h0, req}, 32'h1);
    ack <= 2'h1;
    cyc(1);
    ack <= 2'h0;
    cyc(2);
    $display("test sense done");
  endtask : t_sense

  task automatic t_sleep();
    apb(1'b1, A_CTRL, 32'h0);
    halt_pulse();
    chk({31'h0, clk_stop}, 32'h0);
    apb(1'b1, A_CTRL, 32'h20);
    halt_pulse();
    chk({30'h0, clk_stop, osc_stop}, 32'h2);
    apb(1'b0, A_STAT, 32'h0);
    chk(rd, 32'h1 << POS_STAT_IDLE);
    iwake <= 1'b1;
    wait_wake();
    iwake <= 1'b0;
    chk({31'h0, clk_stop}, 32'h0);
    apb(1'b1, A_CTRL, 32'h30);
    halt_pulse();
    chk({31'h0, osc_stop}, 32'h1);
    apb(1'b0, A_STAT, 32'h0);
    chk(rd, 32'h1 << POS_STAT_PD);
    iwake <= 1'b1;
    cyc(4);
    chk({31'h0, osc_stop}, 32'h1);
    iwake <= 1'b0;
    pull_low <= 2'h1;
    wait_wake();
    cyc(2);
    chk({30'h0, req}, 32'h1);
    pull_low <= 2'h0;
    cyc(8);
    apb(1'b0, A_CTRL, 32'h0);
    chk(rd, 32'h30);
    $display("test sleep done");
  endtask : t_sleep

  // level lost during the start delay: wake, but no request
  task automatic t_pd_drop();
    fuses <= 2'h3;
    halt_pulse();
    chk({31'h0, osc_stop}, 32'h1);
    pull_low <= 2'h1;
    wait_osc_run();
    pull_low <= 2'h0;
    wait_wake();
    chk(32'(waited), 32'(START_3 + 1));
    cyc(2);
    chk({30'h0, req}, 32'h0);
    fuses <= 2'h0;
    $display("test power-down drop done");
  endtask : t_pd_drop

  // reset while asleep lands in run with registers cleared
  task automatic t_reset();
    halt_pulse();
    chk({31'h0, osc_stop}, 32'h1);
    @(posedge pclk);
    presetn <= 1'b0;
    cyc(2);
    presetn <= 1'b1;
    cyc(5);
    chk({30'h0, clk_stop, osc_stop}, 32'h0);
    apb(1'b0, A_CTRL, 32'h0);
    chk(rd, 32'h0);
    $display("test reset in sleep done");
  endtask : t_reset

  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    cyc(5);
    t_regs();
    t_sense();
    t_sleep();
    t_pd_drop();
    t_reset();
    print_verdict();
  end
endmodule : eis_top_test
`default_nettype wire
